// ### core/ccu_capture_unit.sv
// counter a/b pair with shared capture condition and shadow registers
// assumes apb master on pclk; capture sources are asynchronous levels
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps

module ccu_capture_unit
  import ccu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        prescale_1k,
  input  wire logic        prescale_32k,
  input  wire logic        port_a_pin_two,
  input  wire logic        port_a_pin_three,
  output logic             counter_a_interrupt,
  output logic             counter_b_interrupt,
  output logic             irq
);

  function automatic logic [7:0] ccu_step(
    input logic [7:0] v,
    input logic       up
  );
    return up ? v + 8'h01 : v - 8'h01;
  endfunction

  function automatic logic ccu_hit(
    input logic [1:0] sel,
    input logic       now,
    input logic       was
  );
    logic rise;
    logic fall;
    rise = now & ~was;
    fall = ~now & was;
    return (sel == CCU_EDGE_RISE && rise) ||
           (sel == CCU_EDGE_FALL && fall) ||
           (sel == CCU_EDGE_BOTH && (rise || fall));
  endfunction

  logic [1:0]      run;
  logic [1:0]      up;
  logic            cascade_a_b_enable;
  logic [1:0]      capture_edge_select;
  logic [1:0]      capture_source_select;
  logic [1:0][7:0] div;
  logic [1:0][7:0] div_cnt;
  logic [1:0][7:0] cnt;
  logic [1:0][7:0] shadow;
  logic [1:0]      status;
  logic [1:0]      mask;
  logic [3:0]      src_meta;
  logic [3:0]      src_sync;
  logic [1:0]      cap_s1;
  logic [1:0]      cap_s2;
  logic [1:0]      cap_prev;

  wire logic        setup    = psel & ~penable;
  wire logic        wr       = psel & penable & pwrite;
  wire logic        wr_ctrl  = wr && paddr == CCU_CTRL_ADDR;
  wire logic        wr_cfg2  = wr && paddr == CCU_CFG2_ADDR;
  wire logic        wr_div_a = wr && paddr == CCU_DIV_A_ADDR;
  wire logic        wr_div_b = wr && paddr == CCU_DIV_B_ADDR;
  wire logic        wr_cnt_a = wr && paddr == CCU_CNT_A_ADDR;
  wire logic        wr_cnt_b = wr && paddr == CCU_CNT_B_ADDR;
  wire logic        wr_stat  = wr && paddr == CCU_STAT_ADDR;
  wire logic        wr_mask  = wr && paddr == CCU_MASK_ADDR;
  wire logic        cap_on   = capture_edge_select != CCU_EDGE_OFF;
  wire logic        addr_hit = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;

  // counter tick enables; cascaded b runs on a's tick
  wire logic [1:0] raw_tick;
  assign raw_tick[0] = run[0] && div_cnt[0] == div[0];
  assign raw_tick[1] = run[1] && div_cnt[1] == div[1];
  wire logic [1:0] ctick;
  assign ctick[0] = raw_tick[0];
  assign ctick[1] = cascade_a_b_enable ? raw_tick[0] : raw_tick[1];

  // cascaded b follows a's direction
  wire logic dir_b = cascade_a_b_enable ? up[0] : up[1];

  wire logic carry_a = up[0] ? cnt[0] == CCU_CNT_MAX
                             : cnt[0] == CCU_CNT_MIN;
  wire logic step_b  = cascade_a_b_enable ? ctick[0] & carry_a
                                          : ctick[1];

  wire logic [7:0] next_cnt_a = ccu_step(cnt[0], up[0]);
  wire logic [7:0] next_cnt_b = ccu_step(cnt[1], dir_b);

  wire logic sel_src =
    capture_source_select == CCU_SRC_1K        ? src_sync[3] :
    capture_source_select == CCU_SRC_32K       ? src_sync[2] :
    capture_source_select == CCU_SRC_PIN_THREE ? src_sync[1] :
                                                 src_sync[0];

  wire logic [1:0] hit;
  assign hit[0] = ctick[0] &
                  ccu_hit(capture_edge_select, cap_s2[0], cap_prev[0]);
  assign hit[1] = ctick[1] &
                  ccu_hit(capture_edge_select, cap_s2[1], cap_prev[1]);

  wire logic [1:0] cap_event;
  assign cap_event[0] = hit[0] | (cascade_a_b_enable & hit[1]);
  assign cap_event[1] = hit[1] | (cascade_a_b_enable & hit[0]);

  wire logic [1:0] stat_clr = wr_stat ? pwdata[1:0] : 2'h0;

  wire logic [7:0] rd_a = cap_on ? shadow[0] : cnt[0];
  wire logic [7:0] rd_b = cap_on ? shadow[1] : cnt[1];

  wire logic [31:0] rd_data =
    paddr == CCU_CTRL_ADDR  ?
      {27'h0, cascade_a_b_enable, up, run} :
    paddr == CCU_CFG2_ADDR  ?
      {28'h0, capture_source_select, capture_edge_select} :
    paddr == CCU_DIV_A_ADDR ? {24'h0, div[0]} :
    paddr == CCU_DIV_B_ADDR ? {24'h0, div[1]} :
    paddr == CCU_CNT_A_ADDR ? {24'h0, rd_a} :
    paddr == CCU_CNT_B_ADDR ? {24'h0, rd_b} :
    paddr == CCU_STAT_ADDR  ? {30'h0, status} :
    paddr == CCU_MASK_ADDR  ? {30'h0, mask} : 32'h0;

  assign pready              = 1'b1;
  assign pslverr             = psel & penable & ~addr_hit;
  assign counter_a_interrupt = status[0] & mask[0];
  assign counter_b_interrupt = status[1] & mask[1];
  assign irq                 = counter_a_interrupt | counter_b_interrupt;

  // read data latched in setup, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata <= rd_data;
    end
  end

  // software must stop counters before editing these
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cascade_a_b_enable, up, run} <= CCU_CTRL_RST;
      {capture_source_select, capture_edge_select} <= CCU_CFG2_RST;
      mask <= CCU_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        {cascade_a_b_enable, up, run} <= pwdata[CCU_CASCADE_BIT:0];
      end
      if (wr_cfg2) begin
        capture_edge_select   <= pwdata[CCU_EDGE_LSB +: 2];
        capture_source_select <= pwdata[CCU_SRC_LSB +: 2];
      end
      if (wr_mask) begin
        mask <= pwdata[1:0];
      end
    end
  end

  // tick dividers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div     <= {CCU_DIV_RST, CCU_DIV_RST};
      div_cnt <= {CCU_DIV_RST, CCU_DIV_RST};
    end else begin
      if (wr_div_a) begin
        div[0] <= pwdata[7:0];
      end
      if (wr_div_b) begin
        div[1] <= pwdata[7:0];
      end
      for (int i = 0; i < 2; i++) begin
        div_cnt[i] <= raw_tick[i] || !run[i] ? 8'h00
                                             : div_cnt[i] + 8'h01;
      end
    end
  end

  // load by write wins over a tick
  // 8-bit wrap, cascaded via carry into b
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= {CCU_CNT_RST, CCU_CNT_RST};
    end else begin
      if (wr_cnt_a) begin
        cnt[0] <= pwdata[7:0];
      end else if (ctick[0]) begin
        cnt[0] <= next_cnt_a;
      end
      if (wr_cnt_b) begin
        cnt[1] <= pwdata[7:0];
      end else if (step_b) begin
        cnt[1] <= next_cnt_b;
      end
    end
  end

  // two flops on every raw source before the mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_meta <= 4'h0;
      src_sync <= 4'h0;
    end else begin
      src_meta <= {prescale_1k, prescale_32k,
                   port_a_pin_three, port_a_pin_two};
      src_sync <= src_meta;
    end
  end

  // edge history runs even when off, so enabling may fire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_s1   <= 2'h0;
      cap_s2   <= 2'h0;
      cap_prev <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ctick[i]) begin
          cap_s1[i]   <= sel_src;
          cap_s2[i]   <= cap_s1[i];
          cap_prev[i] <= cap_s2[i];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow <= {CCU_CNT_RST, CCU_CNT_RST};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (hit[i]) begin
          shadow[i] <= cnt[i];
        end
      end
    end
  end

  // sticky flags, set wins over clear
  // flag follows capture with no extra delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= CCU_STAT_RST;
    end else begin
      status <= (status & ~stat_clr) | cap_event;
    end
  end

  shadow_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit[0] |=> shadow[0] == $past(cnt[0]))
    else $error("shadow a not loaded with count");

  flag_after_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit[0] |=> status[0])
    else $error("capture a did not set flag");

  read_shadow_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && cap_on && paddr == CCU_CNT_A_ADDR
    |=> prdata[7:0] == $past(shadow[0]))
    else $error("capture read did not return shadow");

  source_one_k_a: assert property (@(posedge pclk) disable iff (!presetn)
    capture_source_select == CCU_SRC_1K |-> sel_src == src_sync[3])
    else $error("source select 1k mismatch");

  edge_off_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    capture_edge_select == CCU_EDGE_OFF |-> hit == 2'h0)
    else $error("capture while disabled");

  rise_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit[0] && capture_edge_select == CCU_EDGE_RISE
    |-> cap_s2[0] && !cap_prev[0])
    else $error("rising capture without rising edge");

  cascade_both_irq_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    cascade_a_b_enable && (hit[0] || hit[1]) |=> status == 2'h3)
    else $error("cascaded capture missed a channel");

  tick_gate_b_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctick[1] |-> !hit[1])
    else $error("capture b outside its tick");

  wrap_up_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctick[0] && up[0] && !wr_cnt_a && cnt[0] == CCU_CNT_MAX
    |=> cnt[0] == CCU_CNT_MIN)
    else $error("up wrap of counter a wrong");

  wrap_down_cas_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    cascade_a_b_enable && ctick[0] && !up[0] && !wr_cnt_a &&
    !wr_cnt_b && cnt == 16'h0
    |=> cnt == 16'hffff)
    else $error("cascaded down wrap wrong");

  count_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctick[0] && !wr_cnt_a && !up[0] && cnt[0] != CCU_CNT_MIN
    |=> cnt[0] == $past(cnt[0]) - 8'h01)
    else $error("down count of counter a wrong");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(status[0]) && mask[0] |-> irq)
    else $error("unmasked flag not on irq");

  shadow_load_b_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit[1] |=> shadow[1] == $past(cnt[1]))
    else $error("shadow b not loaded with count");

  flag_cap_b_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit[1] |=> status[1])
    else $error("capture b did not set flag");

  read_live_b_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && !cap_on && paddr == CCU_CNT_B_ADDR
    |=> prdata[7:0] == $past(cnt[1]))
    else $error("live read of counter b wrong");

endmodule

// ### core/ccu_pkg.sv
// constants of the counter capture unit: register map, fields, codes
// assumes a 32-bit apb slave with word-aligned registers
package ccu_pkg;

  // register byte addresses
  localparam logic [7:0] CCU_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] CCU_CFG2_ADDR   = 8'h04;
  localparam logic [7:0] CCU_DIV_A_ADDR  = 8'h08;
  localparam logic [7:0] CCU_DIV_B_ADDR  = 8'h0c;
  localparam logic [7:0] CCU_CNT_A_ADDR  = 8'h10;
  localparam logic [7:0] CCU_CNT_B_ADDR  = 8'h14;
  localparam logic [7:0] CCU_STAT_ADDR   = 8'h18;
  localparam logic [7:0] CCU_MASK_ADDR   = 8'h1c;

  // control register fields
  localparam int CCU_RUN_LSB     = 0;
  localparam int CCU_UP_LSB      = 2;
  localparam int CCU_CASCADE_BIT = 4;

  // counter_config_two fields
  localparam int CCU_EDGE_LSB = 0;
  localparam int CCU_SRC_LSB  = 2;

  // edge select codes
  localparam logic [1:0] CCU_EDGE_OFF  = 2'h0;
  localparam logic [1:0] CCU_EDGE_RISE = 2'h1;
  localparam logic [1:0] CCU_EDGE_FALL = 2'h2;
  localparam logic [1:0] CCU_EDGE_BOTH = 2'h3;

  // source select codes
  localparam logic [1:0] CCU_SRC_PIN_TWO   = 2'h0;
  localparam logic [1:0] CCU_SRC_PIN_THREE = 2'h1;
  localparam logic [1:0] CCU_SRC_32K       = 2'h2;
  localparam logic [1:0] CCU_SRC_1K        = 2'h3;

  // reset values
  localparam logic [4:0] CCU_CTRL_RST  = 5'h00;
  localparam logic [3:0] CCU_CFG2_RST  = 4'h0;
  localparam logic [7:0] CCU_DIV_RST   = 8'h00;
  localparam logic [7:0] CCU_CNT_RST   = 8'h00;
  localparam logic [1:0] CCU_STAT_RST  = 2'h0;
  localparam logic [1:0] CCU_MASK_RST  = 2'h0;

  // counter wrap values
  localparam logic [7:0] CCU_CNT_MAX = 8'hff;
  localparam logic [7:0] CCU_CNT_MIN = 8'h00;

endpackage

// ### bench/ccu_cpu_model.sv
// apb master standing in for the processor core
// assumes an apb slave on pclk that may stretch the access phase
`timescale 1ns/100ps
module ccu_cpu_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines must not look like the last transfer
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// ### bench/counter_capture_unit_tb_top.sv
// self-checking bench for the counter capture unit
// assumes ccu_cpu_model drives the apb side; sources driven here
`timescale 1ns/100ps
module counter_capture_unit_tb_top
  import ccu_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  src;
  logic        counter_a_interrupt;
  logic        counter_b_interrupt;
  logic        irq;
  int          bad_count;
  int          cmp_count;
  int          cycles;

  ccu_cpu_model i_ccu_cpu_model (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // src bit index equals the source select code
  ccu_capture_unit i_ccu_capture_unit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prescale_1k(src[3]),
    .prescale_32k(src[2]), .port_a_pin_two(src[0]),
    .port_a_pin_three(src[1]),
    .counter_a_interrupt(counter_a_interrupt),
    .counter_b_interrupt(counter_b_interrupt), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 10000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    i_ccu_cpu_model.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    i_ccu_cpu_model.xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic cap_case(input logic [1:0] s, input logic [1:0] g);
    logic [31:0] q;
    logic [31:0] q2;
    logic [4:0]  ctl;
    logic [1:0]  msk;
    int          n;
    ctl = 5'($urandom) | 5'h03;
    msk = 2'($urandom);
    // capture fields changed only while stopped
    wr(CCU_CTRL_ADDR, 32'h0);
    wr(CCU_CFG2_ADDR, {28'h0, s, g});
    src <= {4{g == CCU_EDGE_RISE}};
    wr(CCU_DIV_A_ADDR, 32'($urandom_range(3)));
    wr(CCU_DIV_B_ADDR, 32'($urandom_range(3)));
    wr(CCU_CNT_A_ADDR, 32'hff);
    wr(CCU_CNT_B_ADDR, 32'hff);
    wr(CCU_MASK_ADDR, {30'h0, msk});
    wr(CCU_CTRL_ADDR, {27'h0, ctl});
    // start-up flags are expected, so discard them
    repeat (20) @(posedge pclk);
    wr(CCU_STAT_ADDR, 32'h3);
    src <= src ^ ~(4'h1 << s);
    repeat (20) @(posedge pclk);
    if (g != CCU_EDGE_BOTH)
      src[s] <= ~src[s];
    repeat (20) @(posedge pclk);
    rd(CCU_STAT_ADDR, q);
    check("no capture", q, 32'h0);
    src[s] <= ~src[s];
    q = 32'h0;
    for (n = 0; n < 30 && q !== 32'h3; n++)
      rd(CCU_STAT_ADDR, q);
    check("both flagged", q, 32'h3);
    check("latency", 32'(n <= 6), 32'h1);
    check("irq a", {31'h0, counter_a_interrupt}, {31'h0, msk[0]});
    check("irq b", {31'h0, counter_b_interrupt}, {31'h0, msk[1]});
    check("irq", {31'h0, irq}, {31'h0, |msk});
    // shadow read only after its own flag
    rd(CCU_CNT_A_ADDR, q);
    repeat (8) @(posedge pclk);
    rd(CCU_CNT_A_ADDR, q2);
    check("shadow held", q2, q);
    wr(CCU_STAT_ADDR, 32'h1);
    rd(CCU_STAT_ADDR, q);
    check("clear one", q, 32'h2);
  endtask

  initial begin
    logic [31:0] q;
    logic [31:0] q2;
    logic        e;
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    presetn = 1'b0;
    src = 4'h0;
    void'($urandom(32'h2395));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 32; a += 4) begin
      rd(a[7:0], q);
      check("reset value", q, 32'h0);
    end
    i_ccu_cpu_model.xfer(1'b0, 8'h20, 32'h0, q, e);
    check("unmapped data", q, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
    // direction and wrap, live count with capture off
    for (int k = 0; k < 4; k++) begin
      wr(CCU_CTRL_ADDR, 32'h0);
      wr(CCU_CFG2_ADDR, 32'h0);
      wr(CCU_DIV_A_ADDR, 32'h1f);
      q2 = k[0] ? 32'hff : 32'h0;
      wr(CCU_CNT_A_ADDR, q2);
      wr(CCU_CNT_B_ADDR, q2);
      wr(CCU_CTRL_ADDR, {27'h0, k[1], {2{k[0]}}, 2'h3});
      // edges while capture is off must not flag
      src <= ~src;
      q = q2;
      for (int n = 0; n < 40 && q === q2; n++)
        rd(CCU_CNT_A_ADDR, q);
      check("wrap low", q, {24'h0, ~q2[7:0]});
      rd(CCU_CNT_B_ADDR, q);
      if (k[1])
        check("wrap high", q, {24'h0, ~q2[7:0]});
    end
    rd(CCU_STAT_ADDR, q);
    check("off quiet", q, 32'h0);
    for (int s = 0; s < 4; s++) begin
      for (int g = 1; g < 4; g++) begin
        cap_case(s[1:0], g[1:0]);
      end
    end
    final_report();
  end
endmodule
